// File: hdl/vectoring_pkg.sv
package vectoring_pkg;

	localparam int ADDR_W = 24;
	localparam int NUM_SLOTS = 64;
	localparam int NUM_ORDERED = 42;
	localparam int TABLE_WORDS = 256;
	localparam int TABLE_ENTRIES = 128;

	// Reset vectors and the expanded-mode bus setup.
	localparam logic [23:0] RESET_VEC_EXPANDED = 24'hC00000;
	localparam logic [23:0] RESET_VEC_BOOT_ROM = 24'hFF0000;
	localparam logic [23:0] RESET_VEC_EXP_LOW  = 24'h008000;
	localparam logic [4:0]  EXPANDED_WAIT_STATES = 5'h1F;

	// Mode bits, ordered D C B A from bit 3 down.
	localparam logic [3:0] MODE_EXPANDED     = 4'h0;
	localparam logic [3:0] MODE_EXPANDED_LOW = 4'h8;
	localparam logic [2:0] MODE_RESERVED_CBA = 3'h3;
	localparam int MODE_BIT_C = 2;

	// Synchroniser reset: boot pins low, active-low request pins idle high.
	localparam logic [7:0] PIN_SYNC_RESET = 8'hF0;
	localparam logic [1:0] SETTLE_CYCLES = 2'h3;

	// Slots 0 to 5 are the nonmaskable group.
	localparam logic [5:0] FIRST_MASKABLE_SLOT = 6'h06;
	localparam logic [5:0] EXT_REQ_SLOT = 6'h08;
	localparam logic [1:0] NONMASKABLE_LEVEL = 2'h3;

	// Slots that are tied to a source; every other entry is never chosen.
	localparam logic [63:0] USED_SLOTS = 64'h00071F3F3FFFFF3F; // RULE12 RULE13 RULE14 RULE15 RULE16

	// Slots in service order within one level; slot = vector offset / 2.
	localparam logic [5:0] PRIO_ORDER [0:NUM_ORDERED-1] = '{
		6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h05,
		6'h08, 6'h09, 6'h0A, 6'h0B,
		6'h0C, 6'h0D, 6'h0E, 6'h0F, 6'h10, 6'h11,
		6'h32, 6'h31, 6'h30,
		6'h19, 6'h18, 6'h1A, 6'h1C, 6'h1D, 6'h1B,
		6'h21, 6'h20, 6'h22, 6'h24, 6'h25, 6'h23,
		6'h29, 6'h28, 6'h2A, 6'h2B, 6'h2C,
		6'h13, 6'h12, 6'h15, 6'h14, 6'h17, 6'h16
	};

	// Register byte addresses.
	localparam logic [7:0] REG_MODE       = 8'h00;
	localparam logic [7:0] REG_VECTOR_BASE = 8'h04;
	localparam logic [7:0] REG_LEVEL0     = 8'h08;
	localparam logic [7:0] REG_LEVEL1     = 8'h0C;
	localparam logic [7:0] REG_LEVEL2     = 8'h10;
	localparam logic [7:0] REG_LEVEL3     = 8'h14;
	localparam logic [7:0] REG_CORE_MASK  = 8'h18;
	localparam logic [7:0] REG_START_ADDR = 8'h1C;
	localparam logic [7:0] REG_STATUS     = 8'h20;

	localparam logic [23:0]  VECTOR_BASE_RESET = 24'h000000;
	localparam logic [127:0] LEVELS_RESET = 128'h0;
	localparam logic [1:0]   CORE_MASK_RESET = 2'h3;
	localparam logic [23:0]  START_ADDR_RESET = 24'h000000;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		BOOT_SETTLE = 3'b000,
		BOOT_DECODE = 3'b001,
		BOOT_LOAD   = 3'b010,
		BOOT_RUN    = 3'b011
	} boot_state_t;

	typedef enum logic [2:0] {
		HOST_BUS_NONE    = 3'b000,
		HOST_BUS_ISA     = 3'b001,
		HOST_BUS_NONMUX  = 3'b010,
		HOST_BUS_MUX     = 3'b011,
		HOST_BUS_COMMCTL = 3'b100
	} host_bus_t;

endpackage

// File: hdl/pin_sync.sv
`timescale 1ns/1ps

module pin_sync (
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic [7:0] pin_in,
	output logic      [7:0] pin_out
);

	typedef struct packed {
		logic [7:0] s1;
		logic [7:0] s2;
		logic [7:0] s3;
		logic [7:0] value;
	} sync_t;

	sync_t s_reg;
	sync_t s_next;

	// A change is taken only once the last two stages agree, so a level caught
	// mid-transition in the first stage never reaches the block.
	always_comb begin
		s_next = s_reg;
		s_next.s1 = pin_in;
		s_next.s2 = s_reg.s1;
		s_next.s3 = s_reg.s2;
		for (int i = 0; i < 8; i++) begin
			if (s_reg.s2[i] == s_reg.s3[i]) begin
				s_next.value[i] = s_reg.s3[i];
			end
		end
	end

	// The stages keep sampling through reset, so the boot pins held during reset are
	// already settled when the mode is latched a few edges after release.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_reg.s1    <= s_next.s1;
			s_reg.s2    <= s_next.s2;
			s_reg.s3    <= s_next.s3;
			s_reg.value <= vectoring_pkg::PIN_SYNC_RESET;
		end else begin
			s_reg <= s_next;
		end
	end

	assign pin_out = s_reg.value;

endmodule

// File: hdl/priority_pick.sv
`timescale 1ns/1ps

module priority_pick (
	input  wire logic [63:0]  req,
	input  wire logic [127:0] levels,
	input  wire logic [1:0]   core_mask,
	output logic              sel_valid,
	output logic [5:0]        sel_slot,
	output logic [1:0]        sel_level
);

	logic [vectoring_pkg::NUM_ORDERED-1:0] eligible;
	logic [1:0]                            eff_level [0:vectoring_pkg::NUM_ORDERED-1];

	for (genvar g = 0; g < vectoring_pkg::NUM_ORDERED; g++) begin : g_entry
		localparam logic [5:0] SLOT = vectoring_pkg::PRIO_ORDER[g];
		logic [1:0] field;
		logic       enabled;
		assign field = levels[2*SLOT +: 2];
		// Core sources are always level 3; a zero field disables a maskable one.
		assign enabled = (SLOT < vectoring_pkg::FIRST_MASKABLE_SLOT) || (field != 2'h0);
		assign eff_level[g] = (SLOT < vectoring_pkg::FIRST_MASKABLE_SLOT) ?
			vectoring_pkg::NONMASKABLE_LEVEL : 2'(field - 2'h1); // RULE11
		assign eligible[g] = req[SLOT] && vectoring_pkg::USED_SLOTS[SLOT] && enabled &&
			((eff_level[g] >= core_mask) ||
			(eff_level[g] == vectoring_pkg::NONMASKABLE_LEVEL)); // RULE17
	end

	// Walking in fixed order and replacing only on a strictly higher level keeps the
	// first entry of the highest level.
	always_comb begin
		sel_valid = 1'b0;
		sel_slot = 6'h00;
		sel_level = 2'h0;
		for (int i = 0; i < vectoring_pkg::NUM_ORDERED; i++) begin
			if (eligible[i] && (!sel_valid || (eff_level[i] > sel_level))) begin // RULE19
				sel_valid = 1'b1;
				sel_slot = vectoring_pkg::PRIO_ORDER[i];
				sel_level = eff_level[i];
			end
		end
	end

endmodule

// File: hdl/reset_and_interrupt_vectoring.sv
// The placing of the registers and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/1ps

// Notes on behaviour
// RULE1: Copy synchronised boot pins into mode register.
// RULE2: Mode zero fetches external memory at C00000.
// RULE3: Mode 4: boot ROM, ISA-style host bus.
// RULE4: Mode 5: boot ROM, non-multiplexed host bus.
// RULE5: Mode 6: boot ROM, multiplexed host bus.
// RULE6: Mode 7: boot ROM, communication-controller host bus.
// RULE7: Host flag zero ends loading, jumps start.
// RULE8: Mode 8 fetches 008000, 31 wait states.
// RULE9: Vector table: 256 words from vector base.
// RULE10: Two words per source, 128 entries.
// RULE11: Core level-3 sources at offsets 00 to 0A.
// RULE12: External, DMA, timer vectors from 10 upward.
// RULE13: Serial port 0 vectors at 30 to 3A.
// RULE14: Serial port 1 vectors at 40 to 4A.
// RULE15: Async serial port vectors at 50 to 58.
// RULE16: Host port vectors at 60 to 64.
// RULE17: Unused entries are never chosen by hardware.
// RULE18: Software may reuse unused vector words.
// RULE19: Highest level first, fixed order breaks ties.
// RULE20: Vector address is base plus twice slot; the code replaces base bits 7:0 with twice the slot.
// RULE21: Reserved mode pattern is flagged illegal.
module reset_and_interrupt_vectoring (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic [2:0]  s_axi_awprot,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic [2:0]  s_axi_arprot,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        boot_pin_a,
	input  wire logic        boot_pin_b,
	input  wire logic        boot_pin_c,
	input  wire logic        boot_pin_d,
	input  wire logic        ext_request_a_n,
	input  wire logic        ext_request_b_n,
	input  wire logic        ext_request_c_n,
	input  wire logic        ext_request_d_n,
	input  wire logic [63:0] src_req,
	input  wire logic        host_flag_zero,
	input  wire logic        load_done,
	output logic [23:0]      fetch_addr,
	output logic             fetch_valid,
	output logic             early_exit,
	output logic             loading,
	output logic [2:0]       host_bus_mode,
	output logic             boot_rom_bypass,
	output logic [4:0]       wait_states,
	output logic             mode_illegal,
	output logic             irq_valid,
	output logic [5:0]       irq_slot,
	output logic [1:0]       irq_level,
	output logic [23:0]      irq_vector
);

	typedef struct packed {
		vectoring_pkg::boot_state_t boot;
		logic [1:0]   settle_cnt;
		logic [3:0]   mode;
		logic [23:0]  vbase;
		logic [127:0] levels;
		logic [1:0]   core_mask;
		logic [23:0]  start_addr;
		logic [23:0]  fetch_addr;
		logic         fetch_valid;
		logic         early_exit;
		logic [2:0]   host_bus;
		logic         rom_bypass;
		logic [4:0]   wait_states;
		logic         mode_illegal;
		logic         irq_valid;
		logic [5:0]   irq_slot;
		logic [1:0]   irq_level;
		logic [23:0]  irq_vector;
		logic         aw_got;
		logic [7:0]   aw_addr;
		logic         w_got;
		logic [31:0]  wdata;
		logic [3:0]   wstrb;
		logic         bvalid;
		logic [1:0]   bresp;
		logic         rvalid;
		logic [31:0]  rdata;
		logic [1:0]   rresp;
	} state_t;

	state_t s_reg;
	state_t s_next;

	logic [7:0]  pins_sync;
	logic [63:0] req_all;
	logic        pick_valid;
	logic [5:0]  pick_slot;
	logic [1:0]  pick_level;

	pin_sync u_pin_sync (
		.aclk    (aclk),
		.aresetn (aresetn),
		.pin_in  ({ext_request_d_n, ext_request_c_n, ext_request_b_n, ext_request_a_n,
			boot_pin_d, boot_pin_c, boot_pin_b, boot_pin_a}),
		.pin_out (pins_sync)
	);

	// External request pins are active low and replace the four external slots.
	always_comb begin
		req_all = src_req;
		req_all[vectoring_pkg::EXT_REQ_SLOT +: 4] = ~pins_sync[7:4];
	end

	priority_pick u_priority_pick (
		.req       (req_all),
		.levels    (s_reg.levels),
		.core_mask (s_reg.core_mask),
		.sel_valid (pick_valid),
		.sel_slot  (pick_slot),
		.sel_level (pick_level)
	);

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				r[8*b +: 8] = data[8*b +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic [32:0] read_reg(input state_t s, input logic [7:0] addr);
		logic [32:0] r;
		r = {1'b1, 32'h00000000};
		unique case (addr)
			vectoring_pkg::REG_MODE:        r = {1'b0, 28'h0000000, s.mode};
			vectoring_pkg::REG_VECTOR_BASE: r = {1'b0, 8'h00, s.vbase};
			vectoring_pkg::REG_LEVEL0:      r = {1'b0, s.levels[31:0]};
			vectoring_pkg::REG_LEVEL1:      r = {1'b0, s.levels[63:32]};
			vectoring_pkg::REG_LEVEL2:      r = {1'b0, s.levels[95:64]};
			vectoring_pkg::REG_LEVEL3:      r = {1'b0, s.levels[127:96]};
			vectoring_pkg::REG_CORE_MASK:   r = {1'b0, 30'h00000000, s.core_mask};
			vectoring_pkg::REG_START_ADDR:  r = {1'b0, 8'h00, s.start_addr};
			vectoring_pkg::REG_STATUS:      r = {1'b0, 13'h0000, s.boot, s.host_bus,
				s.mode_illegal, s.irq_valid, s.irq_level, 3'h0, s.irq_slot};
			default:                        r = {1'b1, 32'h00000000};
		endcase
		return r;
	endfunction

	always_comb begin
		logic [31:0] cur;
		logic [31:0] nv;
		logic [32:0] rd;
		logic [1:0]  lvl_idx;
		cur = 32'h00000000;
		nv = 32'h00000000;
		rd = 33'h000000000;
		lvl_idx = 2'h0;
		s_next = s_reg;
		s_next.fetch_valid = 1'b0;
		s_next.early_exit = 1'b0;

		// Write channel: address and data are caught in either order.
		if (s_axi_awvalid && s_axi_awready) begin
			s_next.aw_got = 1'b1;
			s_next.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			s_next.w_got = 1'b1;
			s_next.wdata = s_axi_wdata;
			s_next.wstrb = s_axi_wstrb;
		end
		if (s_reg.bvalid && s_axi_bready) begin
			s_next.bvalid = 1'b0;
		end
		if (s_reg.aw_got && s_reg.w_got) begin
			rd = read_reg(s_reg, s_reg.aw_addr);
			cur = rd[31:0];
			nv = merge(cur, s_reg.wdata, s_reg.wstrb);
			s_next.aw_got = 1'b0;
			s_next.w_got = 1'b0;
			s_next.bvalid = 1'b1;
			s_next.bresp = rd[32] ? vectoring_pkg::RESP_SLVERR : vectoring_pkg::RESP_OKAY;
			unique case (s_reg.aw_addr)
				vectoring_pkg::REG_MODE:        s_next.mode = nv[3:0];
				vectoring_pkg::REG_VECTOR_BASE: s_next.vbase = nv[23:0];
				vectoring_pkg::REG_LEVEL0, vectoring_pkg::REG_LEVEL1,
				vectoring_pkg::REG_LEVEL2, vectoring_pkg::REG_LEVEL3: begin
					lvl_idx = 2'(s_reg.aw_addr[4:2] - 3'h2);
					s_next.levels[32*lvl_idx +: 32] = nv;
				end
				vectoring_pkg::REG_CORE_MASK:   s_next.core_mask = nv[1:0];
				vectoring_pkg::REG_START_ADDR:  s_next.start_addr = nv[23:0];
				default: begin
				end
			endcase
		end

		// Read channel: the answer follows the address by one edge.
		if (s_axi_arvalid && s_axi_arready) begin
			rd = read_reg(s_reg, s_axi_araddr);
			s_next.rvalid = 1'b1;
			s_next.rdata = rd[31:0];
			s_next.rresp = rd[32] ? vectoring_pkg::RESP_SLVERR : vectoring_pkg::RESP_OKAY;
		end else if (s_reg.rvalid && s_axi_rready) begin
			s_next.rvalid = 1'b0;
		end

		unique case (s_reg.boot)
			vectoring_pkg::BOOT_SETTLE: begin
				// Wait out the synchroniser so the pins seen are those held at release.
				s_next.settle_cnt = 2'(s_reg.settle_cnt + 2'h1);
				if (s_reg.settle_cnt == vectoring_pkg::SETTLE_CYCLES) begin
					s_next.mode = pins_sync[3:0]; // RULE1
					s_next.boot = vectoring_pkg::BOOT_DECODE;
				end
			end
			vectoring_pkg::BOOT_DECODE: begin
				s_next.boot = vectoring_pkg::BOOT_RUN;
				s_next.fetch_valid = 1'b1;
				s_next.fetch_addr = vectoring_pkg::RESET_VEC_BOOT_ROM;
				s_next.rom_bypass = 1'b0;
				if (s_reg.mode == vectoring_pkg::MODE_EXPANDED) begin
					s_next.fetch_addr = vectoring_pkg::RESET_VEC_EXPANDED; // RULE2
					s_next.rom_bypass = 1'b1;
					s_next.wait_states = vectoring_pkg::EXPANDED_WAIT_STATES;
				end else if (s_reg.mode == vectoring_pkg::MODE_EXPANDED_LOW) begin
					s_next.fetch_addr = vectoring_pkg::RESET_VEC_EXP_LOW; // RULE8
					s_next.rom_bypass = 1'b1;
					s_next.wait_states = vectoring_pkg::EXPANDED_WAIT_STATES; // RULE8
				end else if (s_reg.mode[vectoring_pkg::MODE_BIT_C]) begin
					s_next.boot = vectoring_pkg::BOOT_LOAD;
					unique case (s_reg.mode[1:0])
						2'h0: s_next.host_bus = vectoring_pkg::HOST_BUS_ISA; // RULE3
						2'h1: s_next.host_bus = vectoring_pkg::HOST_BUS_NONMUX; // RULE4
						2'h2: s_next.host_bus = vectoring_pkg::HOST_BUS_MUX; // RULE5
						2'h3: s_next.host_bus = vectoring_pkg::HOST_BUS_COMMCTL; // RULE6
					endcase
				end else if (s_reg.mode[2:0] == vectoring_pkg::MODE_RESERVED_CBA) begin
					// No vector is offered, so nothing starts from an undefined mode.
					s_next.fetch_valid = 1'b0; // RULE21
					s_next.mode_illegal = 1'b1; // RULE21
				end
			end
			vectoring_pkg::BOOT_LOAD: begin
				if (host_flag_zero || load_done) begin
					s_next.fetch_addr = s_reg.start_addr; // RULE7
					s_next.fetch_valid = 1'b1; // RULE7
					s_next.early_exit = host_flag_zero; // RULE7
					s_next.boot = vectoring_pkg::BOOT_RUN;
				end
			end
			vectoring_pkg::BOOT_RUN: begin
			end
			default: s_next.boot = vectoring_pkg::BOOT_RUN;
		endcase

		// Offsets below 256 words wrap inside the table, so no carry leaves its window.
		s_next.irq_valid = pick_valid; // RULE19
		s_next.irq_slot = pick_slot; // RULE10
		s_next.irq_level = pick_level;
		s_next.irq_vector = {s_reg.vbase[23:8], 8'({pick_slot, 1'b0})}; // RULE9 RULE20
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_reg <= '0;
			s_reg.boot <= vectoring_pkg::BOOT_SETTLE;
			s_reg.vbase <= vectoring_pkg::VECTOR_BASE_RESET;
			s_reg.levels <= vectoring_pkg::LEVELS_RESET;
			s_reg.core_mask <= vectoring_pkg::CORE_MASK_RESET;
			s_reg.start_addr <= vectoring_pkg::START_ADDR_RESET;
			s_reg.host_bus <= vectoring_pkg::HOST_BUS_NONE;
		end else begin
			s_reg <= s_next;
		end
	end

	assign s_axi_awready = !s_reg.aw_got && !s_reg.bvalid;
	assign s_axi_wready = !s_reg.w_got && !s_reg.bvalid;
	assign s_axi_bvalid = s_reg.bvalid;
	assign s_axi_bresp = s_reg.bresp;
	assign s_axi_arready = !s_reg.rvalid;
	assign s_axi_rvalid = s_reg.rvalid;
	assign s_axi_rdata = s_reg.rdata;
	assign s_axi_rresp = s_reg.rresp;
	assign fetch_addr = s_reg.fetch_addr;
	assign fetch_valid = s_reg.fetch_valid;
	assign early_exit = s_reg.early_exit;
	assign loading = (s_reg.boot == vectoring_pkg::BOOT_LOAD);
	assign host_bus_mode = s_reg.host_bus;
	assign boot_rom_bypass = s_reg.rom_bypass;
	assign wait_states = s_reg.wait_states;
	assign mode_illegal = s_reg.mode_illegal;
	assign irq_valid = s_reg.irq_valid;
	assign irq_slot = s_reg.irq_slot;
	assign irq_level = s_reg.irq_level;
	assign irq_vector = s_reg.irq_vector;

endmodule

// File: tb/irq_sources.sv
`timescale 1ns/1ps

module irq_sources (
	input  wire logic        aclk,
	input  wire logic [63:0] want,
	output logic      [63:0] src_req = 64'h0,
	output logic      [3:0]  ext_req_n = 4'hF
);
	// Sources hold a request as a level until the bench withdraws it; no acknowledge exists.
	always @(posedge aclk) begin
		src_req <= want;
		ext_req_n <= ~want[11:8];
	end
endmodule

// File: tb/vectoring_asserts.sv
`timescale 1ns/1ps

module vectoring_asserts (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        boot_pin_a,
	input wire logic        boot_pin_b,
	input wire logic        boot_pin_c,
	input wire logic        boot_pin_d,
	input wire logic [63:0] src_req,
	input wire logic        host_flag_zero,
	input wire logic [23:0] fetch_addr,
	input wire logic        fetch_valid,
	input wire logic        early_exit,
	input wire logic        loading,
	input wire logic [2:0]  host_bus_mode,
	input wire logic        boot_rom_bypass,
	input wire logic [4:0]  wait_states,
	input wire logic        mode_illegal,
	input wire logic        irq_valid,
	input wire logic [5:0]  irq_slot,
	input wire logic [1:0]  irq_level,
	input wire logic [23:0] irq_vector
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_vec_form: assert property (irq_valid |->
		irq_vector[7:0] == {1'b0, irq_slot, 1'b0})
		else $error("vector offset is not twice the slot");
	a_used_only: assert property (irq_valid |-> vectoring_pkg::USED_SLOTS[irq_slot])
		else $error("unused vector entry chosen");
	a_core_level: assert property (irq_valid && irq_slot < 6'h06 |-> irq_level == 2'h3)
		else $error("core source not at top level");
	a_first_core: assert property ($past(aresetn) && src_req[0] |=>
		irq_valid && irq_slot == 6'h00)
		else $error("reset source not chosen first");
	a_expanded: assert property (fetch_valid && !$past(loading) &&
		boot_rom_bypass |-> wait_states == 5'h1F &&
		fetch_addr == (boot_pin_d ? 24'h008000 : 24'hC00000))
		else $error("expanded mode fetch wrong");
	a_rom_entry: assert property (fetch_valid && !$past(loading) &&
		!boot_rom_bypass |-> fetch_addr == 24'hFF0000)
		else $error("boot entry address wrong");
	a_host_bus: assert property (fetch_valid && !$past(loading) &&
		boot_pin_c |-> loading && host_bus_mode == {1'b0, boot_pin_b, boot_pin_a} + 3'h1)
		else $error("host bus setup wrong");
	a_flag_exit: assert property (loading && host_flag_zero |=> fetch_valid && early_exit && !loading)
		else $error("host flag did not end loading");
	a_illegal_stop: assert property (mode_illegal |-> !fetch_valid)
		else $error("fetch started in reserved mode");

	c_early_exit: cover property (fetch_valid && early_exit);
	c_core_irq: cover property (irq_valid && irq_level == 2'h3);
	c_illegal: cover property (mode_illegal);
endmodule

bind reset_and_interrupt_vectoring vectoring_asserts u_vectoring_asserts (
	.aclk(aclk), .aresetn(aresetn), .boot_pin_a(boot_pin_a), .boot_pin_b(boot_pin_b),
	.boot_pin_c(boot_pin_c), .boot_pin_d(boot_pin_d), .src_req(src_req),
	.host_flag_zero(host_flag_zero), .fetch_addr(fetch_addr), .fetch_valid(fetch_valid),
	.early_exit(early_exit), .loading(loading), .host_bus_mode(host_bus_mode),
	.boot_rom_bypass(boot_rom_bypass), .wait_states(wait_states), .mode_illegal(mode_illegal),
	.irq_valid(irq_valid), .irq_slot(irq_slot), .irq_level(irq_level), .irq_vector(irq_vector)
);

// File: tb/tb.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_fail++; \
	$display("[FAIL] %s expected %h seen %h", nm, e, g); end end

module tb;
	logic        aclk = 0, aresetn = 0, hf0 = 0, ldone = 0;
	logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [7:0]  awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, rdata;
	logic [3:0]  pins = 0, ext_n;
	logic [63:0] want = 0, src_req;
	logic        awready, wready, bvalid, arready, rvalid, fetch_valid, early_exit, loading;
	logic        boot_rom_bypass, mode_illegal, irq_valid;
	logic [1:0]  bresp, rresp, irq_level;
	logic [23:0] fetch_addr, irq_vector;
	logic [2:0]  host_bus_mode;
	logic [4:0]  wait_states;
	logic [5:0]  irq_slot;
	int          n_fail = 0, checks_done = 0, seed = 95134;

	always #12.5 aclk = ~aclk;

	irq_sources u_irq_sources (.aclk(aclk), .want(want), .src_req(src_req), .ext_req_n(ext_n));

	reset_and_interrupt_vectoring u_reset_and_interrupt_vectoring (
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.boot_pin_a(pins[0]), .boot_pin_b(pins[1]), .boot_pin_c(pins[2]), .boot_pin_d(pins[3]),
		.ext_request_a_n(ext_n[0]), .ext_request_b_n(ext_n[1]), .ext_request_c_n(ext_n[2]),
		.ext_request_d_n(ext_n[3]), .src_req(src_req), .host_flag_zero(hf0), .load_done(ldone),
		.fetch_addr(fetch_addr), .fetch_valid(fetch_valid), .early_exit(early_exit),
		.loading(loading), .host_bus_mode(host_bus_mode), .boot_rom_bypass(boot_rom_bypass),
		.wait_states(wait_states), .mode_illegal(mode_illegal), .irq_valid(irq_valid),
		.irq_slot(irq_slot), .irq_level(irq_level), .irq_vector(irq_vector)
	);

	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready === 1'b1)
				awvalid <= 1'b0;
			if (wready === 1'b1)
				wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready === 1'b1)
				arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		d = rdata;
		`CHK("read resp", vectoring_pkg::RESP_OKAY, rresp)
		rready <= 1'b0;
	endtask

	// The mode is latched a few edges after release, so pins change only inside reset.
	task automatic boot(input logic [3:0] p);
		aresetn <= 1'b0;
		pins <= p;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
	endtask

	task automatic wait_fetch(output int n);
		n = 0;
		do begin
			@(posedge aclk);
			n++;
		end while (fetch_valid !== 1'b1 && n < 20);
	endtask

	// Winner is the highest level; earlier place in the fixed order wins a tie.
	function automatic logic [8:0] pick(input logic [63:0] rq, input logic [127:0] lv);
		logic [8:0] b;
		logic [5:0] s;
		logic [1:0] f;
		b = 9'h000;
		for (int i = 0; i < vectoring_pkg::NUM_ORDERED; i++) begin
			s = vectoring_pkg::PRIO_ORDER[i];
			if (rq[s] && vectoring_pkg::USED_SLOTS[s] && (s < 6'h06 || lv[2*s +: 2] != 2'h0)) begin
				f = (s < 6'h06) ? 2'h3 : lv[2*s +: 2] - 2'h1;
				if (!b[8] || f > b[7:6])
					b = {1'b1, f, s};
			end
		end
		return b;
	endfunction

	task automatic irq_chk(input logic [63:0] rq, input logic [127:0] lv, input logic [23:0] vb);
		logic [8:0] e;
		want <= rq;
		repeat (8) @(posedge aclk);
		e = pick(rq, lv);
		`CHK("irq valid", e[8], irq_valid)
		if (e[8]) begin
			`CHK("irq choice", e, {irq_valid, irq_level, irq_slot})
			`CHK("irq vector", {vb[23:8], 1'b0, e[5:0], 1'b0}, irq_vector)
		end
	endtask

	task automatic set_levels(input logic [127:0] lv);
		logic [1:0] r;
		for (int i = 0; i < 4; i++)
			wr(vectoring_pkg::REG_LEVEL0 + 8'(4 * i), lv[32*i +: 32], r);
	endtask

	initial begin
		#750000;
		n_fail++;
		stop_test();
	end

	initial begin
		logic [31:0]  d;
		logic [1:0]   r;
		logic [3:0]   p;
		logic [23:0]  st, vb, ev;
		logic [127:0] lv;
		int           n;
		for (int m = 0; m < 9; m++) begin
			p = 4'(m);
			if (m > 0 && m < 8)
				p[3] = 1'($random(seed));
			boot(p);
			wait_fetch(n);
			if (m == 3) begin
				`CHK("no fetch", 20, n)
				`CHK("illegal", 1'b1, mode_illegal)
			end else begin
				ev = (m == 0) ? 24'hC00000 : (m == 8) ? 24'h008000 : 24'hFF0000;
				`CHK("reset vector", ev, fetch_addr)
				`CHK("rom bypass", m % 8 == 0, boot_rom_bypass)
				`CHK("host bus", m[2] ? 3'(m - 3) : 3'h0, host_bus_mode)
				`CHK("wait states", (m % 8 == 0) ? 5'h1F : 5'h00, wait_states)
				`CHK("loading", (m > 3 && m < 8), loading)
			end
			rd(vectoring_pkg::REG_MODE, d);
			`CHK("mode reg", p, d[3:0])
			if (m > 3 && m < 8) begin
				st = 24'($random(seed));
				wr(vectoring_pkg::REG_START_ADDR, {8'h00, st}, r);
				@(posedge aclk);
				if (m == 7)
					ldone <= 1'b1;
				else
					hf0 <= 1'b1;
				wait_fetch(n);
				hf0 <= 1'b0;
				ldone <= 1'b0;
				`CHK("start addr", st, fetch_addr)
				`CHK("early exit", m != 7, early_exit)
				`CHK("loading off", 1'b0, loading)
			end
			$display("boot mode %0d done", m);
		end
		wr(8'h40, 32'hFFFFFFFF, r);
		`CHK("unmapped resp", vectoring_pkg::RESP_SLVERR, r)
		vb = {16'($random(seed)), 8'h00};
		wr(vectoring_pkg::REG_VECTOR_BASE, {8'h00, vb}, r);
		wr(vectoring_pkg::REG_CORE_MASK, 32'h0, r);
		lv = {4{32'h55555555}};
		set_levels(lv);
		for (int s = 0; s < 64; s++)
			irq_chk(64'h1 << s, lv, vb);
		for (int i = 0; i < 40; i++) begin
			if (i % 10 == 0) begin
				lv = {$random(seed), $random(seed), $random(seed), $random(seed)};
				set_levels(lv);
			end
			irq_chk({$random(seed), $random(seed)} & {$random(seed), $random(seed)}, lv, vb);
		end
		want <= 64'h0;
		$display("interrupt tests done");
		stop_test();
	end
endmodule
